// >>> verilog/hsc_pkg.sv
`default_nettype none
package hsc_pkg;
	// ------------------------------------------------------------
	// Bus address and pointer map
	// ------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h40;
	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_HUM  = 8'h01;
	localparam logic [7:0] PTR_CFG  = 8'h02;
	localparam logic [7:0] PTR_SER0 = 8'hfb;
	localparam logic [7:0] PTR_SER1 = 8'hfc;
	localparam logic [7:0] PTR_SER2 = 8'hfd;
	localparam logic [7:0] PTR_MAKR = 8'hfe;
	localparam logic [7:0] PTR_PART = 8'hff;
	localparam logic [7:0] PTR_RST  = 8'h00;

	// ------------------------------------------------------------
	// Configuration field positions within the upper byte
	// ------------------------------------------------------------
	localparam int CFG_HEATER_ENABLE_POS = 5;
	localparam int CFG_BOTH_POS = 4;
	localparam int CFG_LOW_POS  = 3;
	localparam int CFG_TRES_POS = 2;
	localparam int CFG_HRES_POS = 0;
	localparam logic [4:0] CFG_RST = 5'h08;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 20;
	localparam int LINK_PERIOD_NS = 32;
	localparam int SPIKE_NS       = 50;
	localparam int FLT_CYC  = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;
	localparam int START_US = 15000;
	localparam int T14_US   = 6350;
	localparam int T11_US   = 3650;
	localparam int H14_US   = 6500;
	localparam int H11_US   = 3850;
	localparam int H8_US    = 2500;
	localparam int START_CYC = START_US * CLK_MHZ;
	localparam int T14_CYC   = T14_US * CLK_MHZ;
	localparam int T11_CYC   = T11_US * CLK_MHZ;
	localparam int H14_CYC   = H14_US * CLK_MHZ;
	localparam int H11_CYC   = H11_US * CLK_MHZ;
	localparam int H8_CYC    = H8_US * CLK_MHZ;
	localparam int CNT_W     = 19;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       heater_enable;
		logic       both;
		logic       tres;
		logic [1:0] hres;
	} hsc_cfg_t;

	typedef struct packed {
		logic boot_done;
		logic t_ok;
		logic h_ok;
		logic low;
		logic ack;
	} hsc_stat_t;

	typedef struct packed {
		logic [13:0] temp;
		logic [13:0] hum;
	} hsc_res_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX   = 3'h1,
		ST_RACK = 3'h3,
		ST_TX   = 3'h2,
		ST_TACK = 3'h6
	} hsc_lst_t;

	typedef enum logic [1:0] {
		CS_BOOT  = 2'h0,
		CS_SLEEP = 2'h1,
		CS_MEAS_T = 2'h3,
		CS_MEAS_H = 2'h2
	} hsc_cst_t;
endpackage
`default_nettype wire

// >>> verilog/hsc_sensor_slave.sv
// Notes on behaviour
// R01 - Acts only as bus target; never issues START nor starts a transfer.
// R02 - Answers address 1000000 only; any other address is NACKed.
// R03 - No second target with the same address may share the bus.
// R04 - First byte of every write is the pointer, loaded into the pointer.
// R05 - Reads use the last written pointer; pointer-only write just sets it.
// R06 - Master sets the pointer, then restarts with a read address.
// R07 - 16-bit words go high byte first, each byte MSB first.
// R08 - Data written to read-only words is NACKed, word unchanged.
// R09 - A pointer to an unused address is NACKed.
// R10 - During 15 ms start-up only words 0xFB to 0xFF are served.
// R11 - In sleep, configuration, status, result reads and triggers are accepted.
// R12 - A trigger moves from sleep into measurement.
// R13 - After conversion the device returns to sleep by itself.
// R14 - Supply-low flag refreshed after power-on and at each trigger.
// R15 - Heater runs only during measurement, even when enabled.
// R16 - Host may trigger more often to heater_enable faster.
// R17 - Humidity 8/11/14 bits, temperature 11/14 bits, each its own time.
// R18 - Spikes up to 50 ns on clock and data lines are ignored.
// R19 - Pointer write to 0x00 triggers; 0x01 triggers humidity alone.
// R20 - Result reads are NACKed until a conversion has refreshed them.
// R21 - Both-mode measures temperature then humidity; else only the pointed one.
// R22 - Pointer resets to 0x00.
// R23 - Measurement lasts a resolution-dependent count before results update.
// R24 - Acknowledge is driven only during the ninth clock of a byte.
`default_nettype none
module hsc_sensor_slave #(
	parameter int unsigned START_CNT  = hsc_pkg::START_CYC,
	parameter int unsigned T14_CNT    = hsc_pkg::T14_CYC,
	parameter int unsigned T11_CNT    = hsc_pkg::T11_CYC,
	parameter int unsigned H14_CNT    = hsc_pkg::H14_CYC,
	parameter int unsigned H11_CNT    = hsc_pkg::H11_CYC,
	parameter int unsigned H8_CNT     = hsc_pkg::H8_CYC,
	parameter logic [15:0] SERIAL_HI  = 16'h0123, // Arbitrary value
	parameter logic [15:0] SERIAL_MID = 16'h4567, // Arbitrary value
	parameter logic [15:0] SERIAL_LO  = 16'h8900, // Arbitrary value
	parameter logic [15:0] MAKER_ID   = 16'h00a5, // Arbitrary value
	parameter logic [15:0] PART_ID    = 16'h005a  // Arbitrary value
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              link_clk,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire hsc_pkg::hsc_res_t sample,
	input  wire logic              supply_low_in,
	output logic                   heater_on,
	output logic                   measuring
);
	import hsc_pkg::*;

	localparam logic [2:0] FLT_LAST = 3'(FLT_CYC - 1);

	// ------------------------------------------------------------
	// Link-side reset and pin conditioning
	// ------------------------------------------------------------
	logic lrst_s1_ff, lrst_ff;
	logic [1:0] pin_raw, pin_flt;
	assign pin_raw = {scl_in, sda_in};

	// Reset into link domain
	always_ff @(posedge link_clk) begin
		lrst_s1_ff <= rst;
		lrst_ff    <= lrst_s1_ff;
	end

	// Two-stage sync then run-length spike filter per line
	for (genvar gi = 0; gi < 2; gi++) begin : g_pin
		logic       s1_ff, s2_ff, flt_ff;
		logic [2:0] run_ff;
		always_ff @(posedge link_clk) begin
			s1_ff <= pin_raw[gi];
			s2_ff <= s1_ff;
		end
		always_ff @(posedge link_clk) begin
			if (lrst_ff) begin
				run_ff <= 3'h0;
				flt_ff <= 1'b1;
			end else if (s2_ff == flt_ff) begin
				run_ff <= 3'h0;
			end else if (run_ff == FLT_LAST) begin // R18
				flt_ff <= s2_ff;
				run_ff <= 3'h0;
			end else begin
				run_ff <= run_ff + 3'h1;
			end
		end
		assign pin_flt[gi] = flt_ff;
	end

	logic scl_d_ff, sda_d_ff;
	logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
	assign scl      = pin_flt[1];
	assign sda      = pin_flt[0];
	assign scl_rise = scl & ~scl_d_ff;
	assign scl_fall = ~scl & scl_d_ff;
	assign start_ev = scl & scl_d_ff & sda_d_ff & ~sda;
	assign stop_ev  = scl & scl_d_ff & ~sda_d_ff & sda;

	// Previous filtered levels
	always_ff @(posedge link_clk) begin
		scl_d_ff <= scl;
		sda_d_ff <= sda;
	end

	// ------------------------------------------------------------
	// Status from the core domain
	// ------------------------------------------------------------
	hsc_stat_t stat_ff, stat_s1_ff, stat_s2_ff;
	hsc_res_t  res_ff;
	always_ff @(posedge link_clk) begin
		stat_s1_ff <= stat_ff;
		stat_s2_ff <= stat_s1_ff;
	end

	// ------------------------------------------------------------
	// Serial target state machine
	// ------------------------------------------------------------
	hsc_lst_t   lst_ff;
	hsc_cfg_t   cfg_ff;
	logic [3:0] bit_ff;
	logic [2:0] byte_ff;
	logic [7:0] shr_ff, ptr_ff, widx_ff, hold_ff;
	logic [15:0] txw_ff, rd_word;
	logic       rd_ff, ack_ff, mack_ff, txlo_ff, sda_oe_ff;
	logic       req_tog_ff;
	logic [1:0] req_kind_ff;
	logic       boot, busy, dec, nxt_ack;

	assign boot = ~stat_s2_ff.boot_done;
	assign busy = req_tog_ff ^ stat_s2_ff.ack;
	assign dec  = (lst_ff == ST_RX) && (bit_ff == 4'h8) && scl_fall;

	function automatic logic ptr_known(input logic [7:0] p, input logic bt);
		ptr_known = (p >= PTR_SER0) || (!bt && p <= PTR_CFG);
	endfunction

	function automatic logic rd_ok(input logic [7:0] p, input hsc_stat_t s, input logic bz);
		rd_ok = ptr_known(p, !s.boot_done)
			&& !(p == PTR_TEMP && (bz || !s.t_ok))
			&& !(p == PTR_HUM && (bz || !s.h_ok));
	endfunction

	// Word served for the current read index
	always_comb begin
		case (widx_ff)
			PTR_TEMP: rd_word = {res_ff.temp, 2'b00};
			PTR_HUM:  rd_word = {res_ff.hum, 2'b00};
			PTR_CFG:  rd_word = {2'b00, cfg_ff.heater_enable, cfg_ff.both, stat_s2_ff.low,
				cfg_ff.tres, cfg_ff.hres, 8'h00};
			PTR_SER0: rd_word = SERIAL_HI;
			PTR_SER1: rd_word = SERIAL_MID;
			PTR_SER2: rd_word = SERIAL_LO;
			PTR_MAKR: rd_word = MAKER_ID;
			PTR_PART: rd_word = PART_ID;
			default:  rd_word = 16'h0000;
		endcase
	end

	// Acknowledge decision at the end of each received byte
	always_comb begin
		case (byte_ff)
			3'h0:    nxt_ack = (shr_ff[7:1] == DEV_ADDR)
				&& (!shr_ff[0] || rd_ok(ptr_ff, stat_s2_ff, busy)); // R02 R20
			3'h1:    nxt_ack = ptr_known(shr_ff, boot); // R09 R10
			3'h2,
			3'h3:    nxt_ack = (ptr_ff == PTR_CFG); // R08
			default: nxt_ack = 1'b0;
		endcase
	end

	// Bit, byte and state sequencing
	always_ff @(posedge link_clk) begin
		if (lrst_ff) begin
			lst_ff  <= ST_IDLE;
			bit_ff  <= 4'h0;
			byte_ff <= 3'h0;
			shr_ff  <= 8'h00;
			rd_ff   <= 1'b0;
			ack_ff  <= 1'b0;
			mack_ff <= 1'b0;
			txlo_ff <= 1'b0;
			txw_ff  <= 16'h0000;
		end else if (start_ev) begin
			lst_ff  <= ST_RX;
			bit_ff  <= 4'h0;
			byte_ff <= 3'h0;
		end else if (stop_ev) begin
			lst_ff <= ST_IDLE;
			ack_ff <= 1'b0;
		end else begin
			case (lst_ff)
				ST_RX: begin
					if (scl_rise) begin
						shr_ff <= {shr_ff[6:0], sda};
						bit_ff <= bit_ff + 4'h1;
					end else if (dec) begin
						ack_ff <= nxt_ack; // R24
						lst_ff <= ST_RACK;
						if (byte_ff == 3'h0)
							rd_ff <= shr_ff[0];
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						ack_ff  <= 1'b0;
						bit_ff  <= 4'h0;
						txlo_ff <= 1'b0;
						txw_ff  <= rd_word; // R07
						if (!ack_ff)
							lst_ff <= ST_IDLE;
						else if (rd_ff)
							lst_ff <= ST_TX;
						else begin
							lst_ff <= ST_RX;
							if (byte_ff != 3'h4)
								byte_ff <= byte_ff + 3'h1;
						end
					end
				end
				ST_TX: begin
					if (scl_rise)
						bit_ff <= bit_ff + 4'h1;
					else if (scl_fall) begin
						txw_ff <= {txw_ff[14:0], 1'b0}; // R07
						if (bit_ff == 4'h8)
							lst_ff <= ST_TACK;
					end
				end
				ST_TACK: begin
					if (scl_rise)
						mack_ff <= ~sda;
					else if (scl_fall) begin
						bit_ff  <= 4'h0;
						txlo_ff <= ~txlo_ff;
						lst_ff  <= mack_ff ? ST_TX : ST_IDLE;
						if (txlo_ff)
							txw_ff <= rd_word;
					end
				end
				default: lst_ff <= ST_IDLE;
			endcase
		end
	end

	// Pointer, read index, configuration and trigger
	always_ff @(posedge link_clk) begin
		if (lrst_ff) begin
			ptr_ff      <= PTR_RST; // R22
			widx_ff     <= PTR_RST;
			hold_ff     <= 8'h00;
			cfg_ff      <= CFG_RST;
			req_tog_ff  <= 1'b0;
			req_kind_ff <= 2'h0;
		end else if (dec && nxt_ack) begin
			case (byte_ff)
				3'h0: widx_ff <= ptr_ff; // R05
				3'h1: begin
					ptr_ff  <= shr_ff; // R04
					widx_ff <= shr_ff;
					if (shr_ff <= PTR_HUM) begin // R19 R12
						req_tog_ff  <= ~req_tog_ff;
						req_kind_ff <= (shr_ff == PTR_HUM) ? 2'h2
							: (cfg_ff.both ? 2'h3 : 2'h1); // R21
					end
				end
				3'h2: hold_ff <= shr_ff;
				3'h3: cfg_ff <= {hold_ff[CFG_HEATER_ENABLE_POS], hold_ff[CFG_BOTH_POS],
					hold_ff[CFG_TRES_POS], hold_ff[CFG_HRES_POS+1 -: 2]};
				default: hold_ff <= hold_ff;
			endcase
		end else if (lst_ff == ST_TACK && scl_rise && txlo_ff
			&& widx_ff == PTR_TEMP && cfg_ff.both) begin
			widx_ff <= PTR_HUM; // R21
		end
	end

	// Open-drain data drive; clock line is never driven
	always_ff @(posedge link_clk) begin
		if (lrst_ff)
			sda_oe_ff <= 1'b0;
		else
			sda_oe_ff <= (lst_ff == ST_RACK && ack_ff)
				|| (lst_ff == ST_TX && !txw_ff[15]); // R24 R01
	end
	assign sda_oe  = sda_oe_ff;
	assign sda_out = 1'b0;

	// ------------------------------------------------------------
	// Core domain: start-up, measurement and heater
	// ------------------------------------------------------------
	logic       req_s1_ff, req_s2_ff, req_s3_ff, req_s4_ff, new_req;
	logic [1:0] kind_s1_ff, kind_s2_ff, kind_ff;
	hsc_cfg_t   cfg_s1_ff, cfg_s2_ff;
	logic       sup_s1_ff, sup_s2_ff, heater_ff;
	hsc_cst_t   cst_ff;
	logic [CNT_W-1:0] cnt_ff;

	// Link-to-core crossing
	always_ff @(posedge clk) begin
		req_s1_ff  <= req_tog_ff;
		req_s2_ff  <= req_s1_ff;
		req_s3_ff  <= req_s2_ff;
		req_s4_ff  <= req_s3_ff;
		kind_s1_ff <= req_kind_ff;
		kind_s2_ff <= kind_s1_ff;
		cfg_s1_ff  <= cfg_ff;
		cfg_s2_ff  <= cfg_s1_ff;
		sup_s1_ff  <= supply_low_in;
		sup_s2_ff  <= sup_s1_ff;
	end
	assign new_req = req_s3_ff ^ req_s4_ff;

	function automatic logic [CNT_W-1:0] conv_cnt(input logic hum, input hsc_cfg_t c);
		int unsigned n;
		n = T14_CNT;
		if (hum)
			n = (c.hres == 2'h1) ? H11_CNT : (c.hres == 2'h2) ? H8_CNT : H14_CNT;
		else if (c.tres)
			n = T11_CNT;
		conv_cnt = CNT_W'(n - 1);
	endfunction

	// Mode sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			cst_ff  <= CS_BOOT;
			cnt_ff  <= CNT_W'(START_CNT - 1);
			kind_ff <= 2'h0;
		end else if (cst_ff == CS_BOOT) begin
			if (cnt_ff == '0)
				cst_ff <= CS_SLEEP; // R10
			else
				cnt_ff <= cnt_ff - CNT_W'(1);
		end else if (new_req) begin
			kind_ff <= kind_s2_ff;
			cst_ff  <= kind_s2_ff[0] ? CS_MEAS_T : CS_MEAS_H; // R12 R11
			cnt_ff  <= conv_cnt(!kind_s2_ff[0], cfg_s2_ff); // R17 R23
		end else if (cst_ff[1]) begin
			if (cnt_ff != '0)
				cnt_ff <= cnt_ff - CNT_W'(1);
			else if (cst_ff == CS_MEAS_T && kind_ff[1]) begin
				cst_ff <= CS_MEAS_H; // R21
				cnt_ff <= conv_cnt(1'b1, cfg_s2_ff);
			end else
				cst_ff <= CS_SLEEP; // R13
		end
	end
	assign measuring = cst_ff[1];

	// Results, validity and completion handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			res_ff  <= '0;
			stat_ff <= '0;
		end else begin
			stat_ff.boot_done <= (cst_ff != CS_BOOT);
			if (cst_ff != CS_BOOT && new_req) begin
				if (kind_s2_ff[0])
					stat_ff.t_ok <= 1'b0; // R20
				if (kind_s2_ff[1])
					stat_ff.h_ok <= 1'b0;
			end else if (cst_ff[1] && cnt_ff == '0) begin
				if (cst_ff == CS_MEAS_T) begin
					res_ff.temp  <= sample.temp; // R23
					stat_ff.t_ok <= 1'b1;
				end else begin
					res_ff.hum   <= sample.hum;
					stat_ff.h_ok <= 1'b1;
				end
				if (cst_ff == CS_MEAS_H || !kind_ff[1])
					stat_ff.ack <= req_s4_ff;
			end
			if ((cst_ff == CS_BOOT && cnt_ff == '0) || (cst_ff != CS_BOOT && new_req))
				stat_ff.low <= sup_s2_ff; // R14
		end
	end

	// Heater gate
	always_ff @(posedge clk) begin
		if (rst)
			heater_ff <= 1'b0;
		else
			heater_ff <= cfg_s2_ff.heater_enable & cst_ff[1]; // R15
	end
	assign heater_on = heater_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_addr_nack;
		@(posedge link_clk) disable iff (lrst_ff)
		(dec && byte_ff == 3'h0 && shr_ff[7:1] != DEV_ADDR) |=> !ack_ff ##1 !sda_oe_ff;
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked"); // R02
	property p_addr_ack;
		@(posedge link_clk) disable iff (lrst_ff)
		(dec && byte_ff == 3'h0 && shr_ff == {DEV_ADDR, 1'b0}) |=> ack_ff ##1 sda_oe_ff;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own write address not acked"); // R02
	property p_ack_window;
		@(posedge link_clk) disable iff (lrst_ff)
		sda_oe_ff |-> ($past(lst_ff) == ST_RACK || $past(lst_ff) == ST_TX);
	endproperty
	a_ack_window: assert property (p_ack_window) else $error("data driven outside slot"); // R24
	property p_ptr_nack;
		@(posedge link_clk) disable iff (lrst_ff)
		(dec && byte_ff == 3'h1 && !ptr_known(shr_ff, boot)) |=> !ack_ff && $stable(ptr_ff);
	endproperty
	a_ptr_nack: assert property (p_ptr_nack) else $error("unused pointer acked"); // R09
	property p_boot_only;
		@(posedge link_clk) disable iff (lrst_ff)
		(dec && byte_ff == 3'h1 && boot && shr_ff < PTR_SER0) |=> !ack_ff;
	endproperty
	a_boot_only: assert property (p_boot_only) else $error("start-up access accepted"); // R10
	property p_ptr_load;
		@(posedge link_clk) disable iff (lrst_ff)
		(dec && byte_ff == 3'h1 && nxt_ack) |=> ptr_ff == $past(shr_ff);
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // R04
	property p_ro_nack;
		@(posedge link_clk) disable iff (lrst_ff)
		(dec && byte_ff >= 3'h2 && ptr_ff != PTR_CFG) |=> !ack_ff ##1 $stable(cfg_ff);
	endproperty
	a_ro_nack: assert property (p_ro_nack) else $error("read-only write acked"); // R08
	property p_rd_busy;
		@(posedge link_clk) disable iff (lrst_ff)
		(dec && byte_ff == 3'h0 && shr_ff[0] && ptr_ff == PTR_TEMP && busy) |=> !ack_ff;
	endproperty
	a_rd_busy: assert property (p_rd_busy) else $error("stale result acked"); // R20
	property p_msb_first;
		@(posedge link_clk) disable iff (lrst_ff)
		(lst_ff == ST_TX && !start_ev && !stop_ev) |=> sda_oe_ff == !$past(txw_ff[15]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("wrong data bit driven"); // R07
	property p_trig;
		@(posedge clk) disable iff (rst)
		(new_req && cst_ff != CS_BOOT) |=> cst_ff[1] && stat_ff.low == $past(sup_s2_ff);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger not taken"); // R12 R14
	property p_done;
		@(posedge clk) disable iff (rst)
		(cst_ff == CS_MEAS_H && cnt_ff == '0 && !new_req) |=> cst_ff == CS_SLEEP && stat_ff.h_ok;
	endproperty
	a_done: assert property (p_done) else $error("no return to sleep"); // R13 R23
	property p_heater_enable;
		@(posedge clk) disable iff (rst)
		heater_on |-> $past(cst_ff[1]) && $past(cfg_s2_ff.heater_enable);
	endproperty
	a_heater_enable: assert property (p_heater_enable) else $error("heater outside measurement"); // R15
	c_cfg_write: cover property (@(posedge link_clk) dec && byte_ff == 3'h3 && nxt_ack);
	c_result_rd: cover property (@(posedge link_clk) lst_ff == ST_TX && widx_ff == PTR_HUM);
	c_both: cover property (@(posedge clk) cst_ff == CS_MEAS_T ##1 cst_ff == CS_MEAS_H);
	c_foreign: cover property (@(posedge link_clk) dec && byte_ff == 3'h0 && !nxt_ack);
endmodule
`default_nettype wire

// >>> tb/hsc_bus_master.sv
`default_nettype none
module hsc_bus_master (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TL = 1300;
	localparam int TH = 800;

	// Width of a clock spike placed in the low phase of each bit slot, zero for none
	int spike_ns = 0;

	// Idle bus, both lines released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// One bit slot, data moves only while the clock is low
	task automatic bit_slot(input logic v, output logic s);
		#200;
		sda_drv = v;
		#(TL / 2);
		if (spike_ns > 0) begin
			scl = 1'b1;
			#spike_ns;
			scl = 1'b0;
		end
		#(TL / 2 - spike_ns);
		scl = 1'b1;
		#(TH / 2);
		s = sda;
		#(TH / 2);
		scl = 1'b0;
	endtask

	// Start or repeated start
	task automatic start();
		#200;
		sda_drv = 1'b1;
		#TL;
		scl = 1'b1;
		#TH;
		sda_drv = 1'b0;
		#TH;
		scl = 1'b0;
	endtask

	// Stop, then the clock stands still high
	task automatic stop();
		#200;
		sda_drv = 1'b0;
		#TL;
		scl = 1'b1;
		#TH;
		sda_drv = 1'b1;
		#TL;
	endtask

	// Byte out, acknowledge back from the target
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], s);
		end
		bit_slot(1'b1, s);
		ack = (s === 1'b0);
	endtask

	// Byte in, master ends with acknowledge or not
	task automatic rbyte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, s);
			b[i] = s;
		end
		bit_slot(last, s);
	endtask
endmodule
`default_nettype wire

// >>> tb/hsc_sensor_slave_tb.sv
`default_nettype none
module hsc_sensor_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hsc_pkg::*;

	localparam int START = 8000;
	localparam int T14 = 3000;
	localparam int T11 = 2000;
	localparam int H14 = 2500;
	localparam int H11 = 1500;
	localparam int H8 = 1000;
	localparam logic [15:0] MAKER = 16'hc31a; // Arbitrary value
	localparam logic [15:0] PART  = 16'h5e07; // Arbitrary value

	logic     clk = 1'b0;
	logic     link_clk = 1'b0;
	logic     rst = 1'b1;
	logic     scl;
	logic     m_sda;
	wire      sda_w;
	logic     sda_out;
	logic     sda_oe;
	logic     heater_on;
	logic     measuring;
	logic     supply_low_in = 1'b1;
	hsc_res_t sample = '0;
	int       bad_count;
	int       check_count;
	int       cyc;
	int       run_cnt;
	int       meas_len;
	int       meas_ends;
	int       heater_enable_cnt;

	// ------------------------------------------------------------
	// Clocks, wire and instances
	// ------------------------------------------------------------
	always #25 clk = ~clk;
	initial begin
		#7;
		forever #16 link_clk = ~link_clk;
	end

	// Open-drain data line with pull-up, single target
	assign sda_w = (sda_oe ? sda_out : 1'b1) & m_sda;

	hsc_sensor_slave #(.START_CNT(START), .T14_CNT(T14), .T11_CNT(T11), .H14_CNT(H14),
		.H11_CNT(H11), .H8_CNT(H8), .MAKER_ID(MAKER), .PART_ID(PART)) u_dut (
		.clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .sample(sample), .supply_low_in(supply_low_in),
		.heater_on(heater_on), .measuring(measuring));

	hsc_bus_master u_mst (.scl(scl), .sda_drv(m_sda), .sda(sda_w));

	// Length of each measuring run and heater time
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (measuring === 1'b1) begin
			run_cnt <= run_cnt + 1;
		end else if (run_cnt != 0) begin
			meas_len <= run_cnt;
			meas_ends <= meas_ends + 1;
			run_cnt <= 0;
		end
		if (heater_on === 1'b1) begin
			heater_enable_cnt <= heater_enable_cnt + 1;
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic dat,
		input logic [15:0] d, output logic [3:0] ak);
		ak = '0;
		u_mst.start();
		u_mst.wbyte({a, 1'b0}, ak[3]);
		if (ak[3]) u_mst.wbyte(p, ak[2]);
		if (ak[2] && dat) begin
			u_mst.wbyte(d[15:8], ak[1]);
			u_mst.wbyte(d[7:0], ak[0]);
		end
		u_mst.stop();
	endtask

	task automatic rd(input int n, output logic [31:0] v, output logic ak);
		logic [7:0] b;
		v = '0;
		u_mst.start();
		u_mst.wbyte({DEV_ADDR, 1'b1}, ak);
		for (int i = 0; i < n; i++) begin
			if (ak) begin
				u_mst.rbyte(i == n - 1, b);
				v = {v[23:0], b};
			end
		end
		u_mst.stop();
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_boot();
		logic [3:0]  ak;
		logic [31:0] v;
		logic        a;
		rd(2, v, a);
		chk(a, 1'b0);
		wr(7'h41, PTR_CFG, 1'b0, 16'h0, ak);
		chk(ak, 4'h0);
		wr(DEV_ADDR, PTR_CFG, 1'b0, 16'h0, ak);
		chk(ak, 4'h8);
		wr(DEV_ADDR, PTR_MAKR, 1'b0, 16'h0, ak);
		chk(ak, 4'hc);
		rd(2, v, a);
		chk(v, {16'h0, MAKER});
		$display("boot test done");
	endtask

	task automatic t_regs();
		logic [3:0]  ak;
		logic [31:0] v;
		logic        a;
		u_mst.spike_ns = 50;
		wr(DEV_ADDR, PTR_CFG, 1'b0, 16'h0, ak);
		chk(ak, 4'hc);
		rd(2, v, a);
		chk(v, 32'h1800);
		u_mst.spike_ns = 0;
		wr(DEV_ADDR, 8'h10, 1'b0, 16'h0, ak);
		chk(ak, 4'h8);
		wr(DEV_ADDR, PTR_PART, 1'b1, 16'h1234, ak);
		chk(ak, 4'hc);
		rd(2, v, a);
		chk(v, {16'h0, PART});
		$display("register test done");
	endtask

	task automatic t_meas();
		logic [7:0]  cfg[4] = '{8'h30, 8'h02, 8'h04, 8'h01};
		logic [7:0]  ptr[4] = '{8'h00, 8'h01, 8'h00, 8'h01};
		int          lens[4] = '{T14 + H14, H8, T11, H11};
		logic [3:0]  ak;
		logic [31:0] v;
		logic [31:0] e;
		logic        a;
		int          ends0;
		int          n;
		for (int r = 0; r < 4; r++) begin
			@(negedge clk);
			sample.temp = 14'h1234 + 14'(r);
			sample.hum = 14'h0abc + 14'(r);
			supply_low_in = 1'b0;
			heater_enable_cnt = 0;
			ends0 = meas_ends;
			wr(DEV_ADDR, PTR_CFG, 1'b1, {cfg[r], 8'h00}, ak);
			chk(ak, 4'hf);
			wr(DEV_ADDR, ptr[r], 1'b0, 16'h0, ak);
			chk(ak, 4'hc);
			rd(2, v, a);
			chk(a, 1'b0);
			n = 0;
			while (meas_ends == ends0 && n < 20000) begin
				@(negedge clk);
				n++;
			end
			chk(meas_ends != ends0, 1'b1);
			chk(meas_len >= lens[r] - 2 && meas_len <= lens[r] + 6, 1'b1);
			chk(heater_enable_cnt, cfg[r][5] ? meas_len : 0);
			rd(r == 0 ? 4 : 2, v, a);
			e = ptr[r] == 8'h01 ? {16'h0, sample.hum, 2'b00} : {16'h0, sample.temp, 2'b00};
			if (r == 0) e = {sample.temp, 2'b00, sample.hum, 2'b00};
			chk(v, e);
		end
		wr(DEV_ADDR, PTR_CFG, 1'b0, 16'h0, ak);
		rd(2, v, a);
		chk(v, 32'h0100);
		$display("measurement test done");
	endtask

	// Watchdog against a hung bus or a stuck measurement
	initial begin
		#4000000;
		bad_count++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		t_boot();
		while (cyc < START + 40) @(negedge clk);
		t_regs();
		t_meas();
		tally_and_finish();
	end
endmodule
`default_nettype wire
